// ### pkg/chip_mode_pkg.sv
package chip_mode_pkg;

    // widths of the external bus and of the configuration word
    localparam int ADDR_W  = 23;
    localparam int DATA_W  = 32;
    localparam int CS_N    = 4;
    localparam int CFG_W   = 8;

    // mode field codes
    localparam logic [2:0] MODE_MASTER = 3'h7;
    localparam logic [2:0] MODE_SINGLE = 3'h6;
    localparam logic [2:0] MODE_RESET  = 3'h7;

    // fields of the write-once configuration word
    localparam int CFG_SIZE_EN  = 0;
    localparam int CFG_NARROW   = 1;
    localparam int CFG_SHOW_EN  = 2;
    localparam int CFG_CS_LSB   = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // chip select decode position in the address
    localparam int CS_SEL_LSB = 21;

    // emulation chip select meanings
    localparam int EMU_CS_SHOW  = 3;
    localparam int EMU_CS_NOMAP = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_EXT  = 2'b01,
        BUS_SHOW = 2'b10,
        BUS_DONE = 2'b11
    } bus_state_t;

    typedef struct packed {
        logic              valid;
        logic              internal;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [1:0]        size;
        logic [2:0]        code;
    } cpu_req_t;

    typedef struct packed {
        logic              done;
        logic              error;
        logic [DATA_W-1:0] data;
    } cpu_resp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataOut;
        logic [DATA_W-1:0] dataOe;
        logic              readNotWrite;
        logic [2:0]        transferCode;
        logic [1:0]        transferSize;
        logic              outputEnable_n;
        logic [3:0]        byteEnables_n;
        logic [CS_N-1:0]   chipSelect_n;
        logic              showCycleStrobe;
    } ext_out_t;

    function automatic logic isEmulation(input logic [2:0] m);
        return !m[2];
    endfunction : isEmulation

    function automatic logic hasBus(input logic [2:0] m);
        return (m == MODE_MASTER) || !m[2];
    endfunction : hasBus

endpackage : chip_mode_pkg

// ### design/write_once_bits.sv
`timescale 1ns/1ps
module write_once_bits #(
    parameter int                 WIDTH = 8,
    parameter logic [WIDTH-1:0]   RESET = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    // write port
    input  wire logic             wrStrobe,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             debugActive,
    input  wire logic             testActive,
    // stored value
    output logic      [WIDTH-1:0] value
);

    typedef struct packed {
        logic [WIDTH-1:0] bits;
        logic             locked;
    } wo_state_t;

    wo_state_t state_reg;
    wo_state_t state_next;
    logic      freeWrite;

    always_comb begin
        state_next = state_reg;
        freeWrite  = debugActive || testActive;
        // writes in debug or test change the bits but do not set the lock
        if (wrStrobe && (freeWrite || !state_reg.locked)) begin
            state_next.bits = wrData;
            if (!freeWrite) begin
                state_next.locked = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '{bits: RESET, locked: 1'b0};
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.bits;

endmodule : write_once_bits

// ### design/chip_mode_config.sv
`timescale 1ns/1ps
module chip_mode_config #(
    parameter logic [chip_mode_pkg::CS_N-1:0] CS_AUTO_ACK = 4'h0
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic                              clkEn,
    // mode strap and debug state
    input  wire logic [2:0]                        modeStrap,
    input  wire logic                              debugActive,
    input  wire logic                              testActive,
    // write-once configuration
    input  wire logic                              cfgWrite,
    input  wire logic [chip_mode_pkg::CFG_W-1:0]   cfgData,
    // processor side
    input  wire chip_mode_pkg::cpu_req_t           cpuReq,
    output chip_mode_pkg::cpu_resp_t               cpuResp,
    output logic                                   cpuReady,
    // general purpose I/O on bus pins
    input  wire logic [chip_mode_pkg::DATA_W-1:0]  gpioOut,
    input  wire logic [chip_mode_pkg::DATA_W-1:0]  gpioOe,
    input  wire logic [1:0]                        gpioByteEnOut,
    output logic      [chip_mode_pkg::DATA_W-1:0]  gpioIn,
    // external pins
    input  wire logic [chip_mode_pkg::DATA_W-1:0]  extDataIn,
    input  wire logic                              transferAck,
    input  wire logic                              transferErrorAck,
    output chip_mode_pkg::ext_out_t                extOut,
    // status
    output logic      [2:0]                        modeField,
    output logic      [chip_mode_pkg::CFG_W-1:0]   cfgValue
);

    typedef struct packed {
        chip_mode_pkg::bus_state_t         fsm;
        logic                              modeValid;
        logic [2:0]                        mode;
        logic                              autoAck;
        chip_mode_pkg::ext_out_t           pins;
        chip_mode_pkg::cpu_resp_t          resp;
        logic                              ready;
        logic [chip_mode_pkg::DATA_W-1:0]  gpioIn;
        logic [chip_mode_pkg::CFG_W-1:0]   cfg;
    } top_state_t;

    top_state_t                       state_reg;
    top_state_t                       state_next;
    logic [chip_mode_pkg::CFG_W-1:0]  cfgBits;

    write_once_bits #(
        .WIDTH (chip_mode_pkg::CFG_W),
        .RESET (chip_mode_pkg::CFG_RESET)
    ) cfgStore (
        .clk         (clk),
        .reset       (reset),
        .clkEn       (clkEn),
        .wrStrobe    (cfgWrite),
        .wrData      (cfgData),
        .debugActive (debugActive),
        .testActive  (testActive),
        .value       (cfgBits)
    );

    function automatic chip_mode_pkg::ext_out_t idlePins();
        chip_mode_pkg::ext_out_t p;
        p                 = '0;
        p.readNotWrite    = 1'b1;
        p.outputEnable_n  = 1'b1;
        p.byteEnables_n   = 4'hf;
        p.chipSelect_n    = {chip_mode_pkg::CS_N{1'b1}};
        return p;
    endfunction : idlePins

    logic                            emul;
    logic                            busOn;
    logic                            narrow;
    logic [1:0]                      csIdx;
    logic                            csHit;
    logic [chip_mode_pkg::CS_N-1:0]  csEnable;
    logic [3:0]                      laneEn;
    logic                            ackSeen;

    always_comb begin
        state_next = state_reg;
        emul       = chip_mode_pkg::isEmulation(state_reg.mode);
        busOn      = chip_mode_pkg::hasBus(state_reg.mode);
        narrow     = state_reg.cfg[chip_mode_pkg::CFG_NARROW];
        csEnable   = state_reg.cfg[chip_mode_pkg::CFG_CS_LSB +: chip_mode_pkg::CS_N];
        csIdx      = cpuReq.addr[chip_mode_pkg::CS_SEL_LSB +: 2];
        csHit      = csEnable[csIdx];
        ackSeen    = transferAck || transferErrorAck || state_reg.autoAck;
        state_next.cfg = cfgBits;

        // strap taken once after release, never again
        if (!state_reg.modeValid) begin
            state_next.mode      = modeStrap;
            state_next.modeValid = 1'b1;
        end

        state_next.resp.done  = 1'b0;
        state_next.resp.error = 1'b0;
        state_next.pins.showCycleStrobe = 1'b0;

        // byte lanes for size: 32-bit uses all, narrow bus the upper two only
        unique case (cpuReq.size)
            2'b01:   laneEn = 4'h8 >> cpuReq.addr[1:0];
            2'b10:   laneEn = cpuReq.addr[1] ? 4'h3 : 4'hc;
            default: laneEn = 4'hf;
        endcase
        if (narrow) begin
            laneEn = {laneEn[3:2] | laneEn[1:0], 2'b00};
        end

        unique case (state_reg.fsm)
            chip_mode_pkg::BUS_IDLE: begin
                state_next.ready = state_reg.modeValid;
                if (cpuReq.valid && state_reg.ready) begin
                    state_next.ready = 1'b0;
                    if (cpuReq.internal) begin
                        // internal transfer is only shown on the bus in emulation
                        if (emul && state_reg.cfg[chip_mode_pkg::CFG_SHOW_EN]) begin
                            state_next.pins.addr  = cpuReq.addr;
                            state_next.pins.dataOut = cpuReq.data;
                            state_next.pins.dataOe  = {chip_mode_pkg::DATA_W{1'b1}};
                            state_next.pins.readNotWrite = !cpuReq.write;
                            state_next.pins.transferCode = cpuReq.code;
                            state_next.pins.showCycleStrobe = 1'b1;
                            state_next.pins.chipSelect_n[chip_mode_pkg::EMU_CS_SHOW] =
                                1'b0;
                            state_next.fsm = chip_mode_pkg::BUS_SHOW;
                        end else begin
                            state_next.fsm = chip_mode_pkg::BUS_DONE;
                        end
                    end else if (!busOn) begin
                        // no external memory exists in single-chip mode
                        state_next.resp.done  = 1'b1;
                        state_next.resp.error = 1'b1;
                        state_next.fsm        = chip_mode_pkg::BUS_DONE;
                    end else begin
                        state_next.pins.addr         = cpuReq.addr;
                        state_next.pins.readNotWrite = !cpuReq.write;
                        state_next.pins.transferCode = cpuReq.code;
                        state_next.pins.transferSize =
                            state_reg.cfg[chip_mode_pkg::CFG_SIZE_EN] ? cpuReq.size : 2'b00;
                        state_next.pins.outputEnable_n = cpuReq.write;
                        state_next.pins.byteEnables_n  = ~laneEn;
                        state_next.pins.dataOut = cpuReq.data;
                        state_next.pins.dataOe  = cpuReq.write ?
                            (narrow ? 32'hffff_0000 : 32'hffff_ffff) : '0;
                        if (csHit) begin
                            state_next.pins.chipSelect_n[csIdx] = 1'b0;
                            state_next.autoAck = CS_AUTO_ACK[csIdx];
                        end else if (emul) begin
                            state_next.pins.chipSelect_n[chip_mode_pkg::EMU_CS_NOMAP] =
                                1'b0;
                        end
                        state_next.fsm = chip_mode_pkg::BUS_EXT;
                    end
                end
            end
            chip_mode_pkg::BUS_EXT: begin
                // cycle ends on either acknowledge or a self-terminating select
                if (ackSeen) begin
                    state_next.resp.done  = 1'b1;
                    state_next.resp.error = transferErrorAck;
                    state_next.resp.data  = extDataIn;
                    state_next.autoAck    = 1'b0;
                    state_next.pins       = idlePins();
                    state_next.fsm        = chip_mode_pkg::BUS_DONE;
                end
            end
            chip_mode_pkg::BUS_SHOW: begin
                state_next.pins = idlePins();
                state_next.fsm  = chip_mode_pkg::BUS_DONE;
            end
            chip_mode_pkg::BUS_DONE: begin
                state_next.ready = 1'b1;
                state_next.fsm   = chip_mode_pkg::BUS_IDLE;
            end
        endcase

        // pins left to general purpose I/O when the bus does not own them
        if (!busOn) begin
            state_next.pins.dataOut = gpioOut;
            state_next.pins.dataOe  = gpioOe;
            state_next.pins.byteEnables_n = {gpioByteEnOut, 2'b11};
        end else if (narrow && state_reg.fsm == chip_mode_pkg::BUS_IDLE) begin
            state_next.pins.dataOut[15:0] = gpioOut[15:0];
            state_next.pins.dataOe[15:0]  = gpioOe[15:0];
        end
        state_next.gpioIn = extDataIn;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg           <= '0;
            state_reg.fsm       <= chip_mode_pkg::BUS_IDLE;
            state_reg.mode      <= chip_mode_pkg::MODE_RESET;
            state_reg.pins      <= idlePins();
            state_reg.cfg       <= chip_mode_pkg::CFG_RESET;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign extOut    = state_reg.pins;
    assign cpuResp   = state_reg.resp;
    assign cpuReady  = state_reg.ready;
    assign gpioIn    = state_reg.gpioIn;
    assign modeField = state_reg.mode;
    assign cfgValue  = state_reg.cfg;

endmodule : chip_mode_config

// ### bench/chip_mode_config_properties.sv
`timescale 1ns/1ps
module chip_mode_config_properties #(
    parameter logic [chip_mode_pkg::CS_N-1:0] CS_AUTO_ACK = 4'h0
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     clkEn,
    // configuration
    input wire logic                     debugActive,
    input wire logic                     testActive,
    input wire logic                     cfgWrite,
    input wire logic [7:0]               cfgData,
    input wire logic [7:0]               cfgValue,
    input wire logic [2:0]               modeField,
    // processor side
    input wire chip_mode_pkg::cpu_req_t  cpuReq,
    input wire chip_mode_pkg::cpu_resp_t cpuResp,
    input wire logic                     cpuReady,
    // external pins
    input wire logic                     transferAck,
    input wire logic                     transferErrorAck,
    input wire chip_mode_pkg::ext_out_t  extOut
);
    logic locked_reg;
    logic pinsOn;
    assign pinsOn = (extOut.chipSelect_n != 4'hf) && !extOut.showCycleStrobe;
    // first plain write closes the write-once bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            locked_reg <= 1'b0;
        end else if (clkEn && cfgWrite && !debugActive && !testActive) begin
            locked_reg <= 1'b1;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence take_s;
        clkEn && cpuReq.valid && cpuReady;
    endsequence
    sequence ext_take_s;
        take_s ##0 (!cpuReq.internal && modeField == chip_mode_pkg::MODE_MASTER);
    endsequence
    sequence single_take_s;
        take_s ##0 (!cpuReq.internal && modeField == chip_mode_pkg::MODE_SINGLE);
    endsequence
    sequence ready_back_s;
        !cpuReady ##1 (!cpuResp.done && cpuReady);
    endsequence
    mode_hold_a: assert property (cpuReady |-> $stable(modeField))
        else $error("mode field changed after capture");
    mode_init_a: assert property ($past(reset) |-> modeField == chip_mode_pkg::MODE_RESET)
        else $error("mode field not at reset value");
    bus_drive_a: assert property (ext_take_s |=> extOut.addr == $past(cpuReq.addr)
        && extOut.readNotWrite == !$past(cpuReq.write) && !cpuReady) else $error("bus not driven");
    ack_done_a: assert property (pinsOn && transferAck && !transferErrorAck
        |=> cpuResp.done && !cpuResp.error) else $error("ack did not end cycle");
    err_done_a: assert property (pinsOn && transferErrorAck |=> cpuResp.done && cpuResp.error)
        else $error("error ack not reported");
    done_once_a: assert property (cpuResp.done |-> ready_back_s)
        else $error("done pulse or ready return wrong");
    show_cs_a: assert property (extOut.showCycleStrobe |-> !modeField[2]
        && !extOut.chipSelect_n[chip_mode_pkg::EMU_CS_SHOW] ##1 !extOut.showCycleStrobe)
        else $error("show strobe wrong");
    single_pins_a: assert property (modeField == chip_mode_pkg::MODE_SINGLE
        |-> extOut.chipSelect_n == 4'hf && extOut.outputEnable_n) else $error("bus active");
    single_err_a: assert property (single_take_s |=> cpuResp.done && cpuResp.error)
        else $error("single-chip external access not refused");
    cfg_lock_a: assert property (locked_reg && cfgWrite && !debugActive && !testActive
        |=> ##1 $stable(cfgValue)) else $error("locked config changed");
    cfg_free_a: assert property (cfgWrite && (debugActive || testActive)
        |=> ##1 cfgValue == $past(cfgData, 2)) else $error("debug config write lost");
endmodule : chip_mode_config_properties

bind chip_mode_config chip_mode_config_properties #(.CS_AUTO_ACK(CS_AUTO_ACK)) i_props (
    .clk, .reset, .clkEn, .debugActive, .testActive, .cfgWrite, .cfgData, .cfgValue,
    .modeField, .cpuReq, .cpuResp, .cpuReady, .transferAck, .transferErrorAck, .extOut
);

// ### bench/ext_memory_model.sv
`timescale 1ns/1ps
module ext_memory_model (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    reset,
    // test control
    input wire logic [3:0]              waitCycles,
    input wire logic                    failNext,
    // bus pins
    input wire chip_mode_pkg::ext_out_t extOut,
    output logic [31:0]                 extDataIn,
    output logic                        transferAck,
    output logic                        transferErrorAck,
    output logic [22:0]                 showAddr
);
    logic [3:0] count;
    logic       selected;
    // only a chip select opens a cycle; byte enables double as I/O in single-chip mode
    assign selected = (extOut.chipSelect_n != 4'hf) && !extOut.showCycleStrobe;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            transferAck <= 1'b0;
            transferErrorAck <= 1'b0;
            count <= 4'h0;
            extDataIn <= '0;
            showAddr <= '0;
        end else begin
            // released data lines never keep the last word
            extDataIn <= ~extDataIn;
            transferAck <= 1'b0;
            transferErrorAck <= 1'b0;
            count <= 4'h0;
            if (extOut.showCycleStrobe) begin
                showAddr <= extOut.addr;
            end
            if (selected && !transferAck && !transferErrorAck) begin
                count <= count + 4'h1;
                if (count == waitCycles) begin
                    transferAck <= !failNext;
                    transferErrorAck <= failNext;
                    extDataIn <= {9'h000, extOut.addr};
                end
            end
        end
    end
endmodule : ext_memory_model

// ### bench/chip_mode_config_tb.sv
`timescale 1ns/1ps
module chip_mode_config_tb;
    logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, cfgWrite = 1'b0, failNext = 1'b0;
    logic debugActive = 1'b0, testActive = 1'b0, cpuReady, transferAck, transferErrorAck;
    logic [2:0] modeStrap = 3'h7, modeField;
    logic [7:0] cfgData = 8'h00, cfgValue;
    logic [31:0] gpioOut = '0, gpioOe = '0, gpioIn, extDataIn;
    logic [1:0] gpioByteEnOut = 2'h0;
    logic [3:0] waitCycles = 4'h2;
    logic [22:0] showAddr;
    chip_mode_pkg::cpu_req_t cpuReq = '0;
    chip_mode_pkg::cpu_resp_t cpuResp, resp;
    chip_mode_pkg::ext_out_t extOut, pins;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #2.5 clk = ~clk;
    chip_mode_config i_dut (.clk, .reset, .clkEn, .modeStrap, .debugActive, .testActive,
        .cfgWrite, .cfgData, .cpuReq, .cpuResp, .cpuReady, .gpioOut, .gpioOe, .gpioByteEnOut,
        .gpioIn, .extDataIn, .transferAck, .transferErrorAck, .extOut, .modeField, .cfgValue);
    ext_memory_model i_mem (.clk, .reset, .waitCycles, .failNext, .extOut, .extDataIn,
        .transferAck, .transferErrorAck, .showAddr);
    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic start(input logic [2:0] mode);
        @(negedge clk);
        reset = 1'b1;
        modeStrap = mode;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
    endtask : start
    task automatic cfg(input logic [7:0] v);
        cfgData = v;
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        repeat (2) @(negedge clk);
    endtask : cfg
    task automatic access(input logic wr, intl, input logic [22:0] a, input logic [31:0] d,
        input logic [1:0] sz);
        int n;
        n = 0;
        while (cpuReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cpuReq = '{1'b1, intl, wr, a, d, sz, 3'h5};
        @(negedge clk);
        cpuReq.valid = 1'b0;
        pins = extOut;
        n = 0;
        while (cpuResp.done !== 1'b1 && !(intl && cpuReady === 1'b1) && n < 20) begin
            @(negedge clk);
            n++;
        end
        resp = cpuResp;
    endtask : access
    task automatic s_modes;
        logic [2:0] straps [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
        logic [2:0] masks [4] = '{3'h7, 3'h7, 3'h6, 3'h4};
        // factory-test strap only visited here, never with traffic
        for (int i = 0; i < 4; i++) begin
            start(straps[i]);
            modeStrap = ~straps[i];
            repeat (3) @(negedge clk);
            chk(32'(modeField & masks[i]), 32'(straps[i] & masks[i]));
        end
    endtask : s_modes
    task automatic s_master;
        start(3'h7);
        cfg(8'hf1);
        waitCycles = 4'h3;
        access(1'b0, 1'b0, 23'h00_1004, 32'h0000_0000, 2'h0);
        chk(resp.data, 32'h0000_1004);
        chk(32'(pins.chipSelect_n), 32'h0000_000e);
        chk(32'(pins.byteEnables_n), 32'h0000_0000);
        chk(32'({pins.outputEnable_n, pins.transferCode}), 32'h0000_0005);
        waitCycles = 4'h0;
        access(1'b1, 1'b0, 23'h60_0002, 32'h1234_abcd, 2'h1);
        chk(32'({pins.chipSelect_n, pins.byteEnables_n}), 32'h0000_007d);
        chk(32'(pins.readNotWrite), 32'h0000_0000);
        chk(pins.dataOut, 32'h1234_abcd);
        chk(32'(pins.transferSize), 32'h0000_0001);
        failNext = 1'b1;
        access(1'b0, 1'b0, 23'h20_0000, 32'h0000_0000, 2'h0);
        failNext = 1'b0;
        chk(32'({resp.done, resp.error}), 32'h0000_0003);
        cfg(8'h00);
        chk(32'(cfgValue), 32'h0000_00f1);
        debugActive = 1'b1;
        cfg(8'h13);
        debugActive = 1'b0;
        chk(32'(cfgValue), 32'h0000_0013);
        gpioOe = 32'h0000_ffff;
        gpioOut = 32'h0000_5a5a;
        repeat (2) @(negedge clk);
        chk(extOut.dataOe, 32'h0000_ffff);
        chk(32'(extOut.dataOut[15:0]), 32'h0000_5a5a);
        // lower lanes released by I/O so only the bus drive is seen
        gpioOe = '0;
        access(1'b1, 1'b0, 23'h00_0000, 32'h89ab_cdef, 2'h2);
        chk(pins.dataOe, 32'hffff_0000);
        chk(32'(pins.byteEnables_n), 32'h0000_0003);
    endtask : s_master
    task automatic s_single;
        start(3'h6);
        gpioOe = 32'hffff_ffff;
        gpioOut = 32'h1357_9bdf;
        gpioByteEnOut = 2'h1;
        repeat (2) @(negedge clk);
        chk(extOut.dataOut, 32'h1357_9bdf);
        chk(32'(extOut.byteEnables_n), 32'h0000_0007);
        chk(gpioIn, ~extDataIn);
        access(1'b0, 1'b0, 23'h00_0040, 32'h0000_0000, 2'h0);
        chk(32'({resp.done, resp.error}), 32'h0000_0003);
        gpioOe = '0;
        gpioByteEnOut = 2'h0;
    endtask : s_single
    task automatic s_emu;
        start(3'h0);
        testActive = 1'b1;
        cfg(8'h01);
        testActive = 1'b0;
        cfg(8'h05);
        chk(32'(cfgValue), 32'h0000_0005);
        access(1'b0, 1'b1, 23'h01_2340, 32'h0000_0000, 2'h0);
        chk(32'(showAddr), 32'h0001_2340);
        chk(32'(pins.chipSelect_n[3]), 32'h0000_0000);
        waitCycles = 4'h1;
        access(1'b0, 1'b0, 23'h40_0008, 32'h0000_0000, 2'h0);
        chk(resp.data, 32'h0040_0008);
        chk(32'(pins.chipSelect_n[2]), 32'h0000_0000);
    endtask : s_emu
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up;
        end
    end
    initial begin
        s_modes;
        s_master;
        s_single;
        s_emu;
        wrap_up;
    end
endmodule : chip_mode_config_tb
